// ---- bench/mc_link_core_model.sv ----
// Behavioural link core that answers register reads after a chosen delay
`timescale 1ns/10ps
module mc_link_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Access from the bus side and answer delay
  input wire logic link_req_i,
  input wire logic link_clock_running_i,
  input wire logic [1:0] delay_i,
  // Answer to the guard
  output logic ack_o = 1'b0,
  output logic [31:0] rdata_o = 32'h0
);
  // ----------------------------------------------------------------
  // Answer timing
  // ----------------------------------------------------------------
  localparam logic [31:0] ANSWER = 32'h1234abcd;
  logic [2:0] wait_cnt;

  // Sample on the rising edge, a running clock only
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_cnt <= 3'h0;
    end else if (link_req_i && link_clock_running_i) begin
      wait_cnt <= {1'b0, delay_i} + 3'h1;
    end else if (wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
    end
  end

  // Drive off the sampling edge; idle data inverts each cycle, so after an answer it matches that value every other cycle
  always @(negedge clk_i) begin
    ack_o <= (wait_cnt == 3'h1);
    rdata_o <= (wait_cnt == 3'h1) ? ANSWER : ~rdata_o;
  end
endmodule // mc_link_core_model

// ---- bench/tb_pci_misc_config_register.sv ----
// Self-checking bench for the miscellaneous bus configuration register
`timescale 1ns/10ps
module tb_pci_misc_config_register import mc_pkg::*; ();
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0, reset_n_i = 1'b0, bus_reset_i = 1'b0;
  logic cfg_req_i = 1'b0, cfg_wr_i = 1'b0, eeprom_load_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00, mrd_phases_i = 8'h00;
  logic [3:0] cfg_be_i = 4'h0, mrd_cmd_o;
  logic [31:0] cfg_wdata_i = 32'h0, irq_event_i = 32'h0, irq_mask_i = 32'h0;
  logic [31:0] cfg_rdata_o, link_resp_data_o, link_core_rdata_i;
  logic [1:0] eeprom_word12_i = 2'h0, delay = 2'h0;
  logic master_interrupt_gate_i = 1'b0, mrd_req_i = 1'b0, link_req_i = 1'b0, link_clock_running_i = 1'b0;
  logic gpio_three_out_i = 1'b0, gpio_three_drive_i = 1'b0, gpio_two_out_i = 1'b0, gpio_two_drive_i = 1'b0;
  logic link_gate_request_i = 1'b0, bus_gate_request_i = 1'b0, ext_three = 1'b1, ext_two = 1'b1, ext_six = 1'b1;
  logic cfg_ack_o, pme_from_cold_support_o, vendor_pme_ignore_o, pme_request_o, mrd_valid_o, link_core_ack_i;
  logic link_resp_valid_o, link_resp_abort_o, gp_pin_three_o, gp_pin_three_oe_n_o, gp_pin_two_o, gp_pin_two_oe_n_o;
  logic eeprom_scl_o, eeprom_sda_o, link_clock_enable_o, bus_clock_enable_o;
  logic multifunction_pin_six_o, multifunction_pin_six_oe_n_o, bus_clock_stop_ok_o;
  int failures = 0, check_count = 0;
  // Pin levels: the driver wins, else the board pull-up or test value
  wire logic gp_pin_three_i = gp_pin_three_oe_n_o ? ext_three : gp_pin_three_o;
  wire logic gp_pin_two_i = gp_pin_two_oe_n_o ? ext_two : gp_pin_two_o;
  wire logic multifunction_pin_six_i = multifunction_pin_six_oe_n_o ? ext_six : multifunction_pin_six_o;

  always #2 clk_i = ~clk_i;

  mc_misc_config mc_misc_config_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_reset_i(bus_reset_i),
    .cfg_req_i(cfg_req_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o),
    .eeprom_load_i(eeprom_load_i), .eeprom_word12_i(eeprom_word12_i),
    .pme_from_cold_support_o(pme_from_cold_support_o), .vendor_pme_ignore_o(vendor_pme_ignore_o),
    .irq_event_i(irq_event_i), .irq_mask_i(irq_mask_i), .master_interrupt_gate_i(master_interrupt_gate_i),
    .pme_request_o(pme_request_o), .mrd_req_i(mrd_req_i), .mrd_phases_i(mrd_phases_i),
    .mrd_valid_o(mrd_valid_o), .mrd_cmd_o(mrd_cmd_o), .link_req_i(link_req_i),
    .link_clock_running_i(link_clock_running_i), .link_core_ack_i(link_core_ack_i),
    .link_core_rdata_i(link_core_rdata_i), .link_resp_valid_o(link_resp_valid_o),
    .link_resp_abort_o(link_resp_abort_o), .link_resp_data_o(link_resp_data_o),
    .gp_pin_three_i(gp_pin_three_i), .gp_pin_two_i(gp_pin_two_i), .gpio_three_out_i(gpio_three_out_i),
    .gpio_three_drive_i(gpio_three_drive_i), .gpio_two_out_i(gpio_two_out_i),
    .gpio_two_drive_i(gpio_two_drive_i), .gp_pin_three_o(gp_pin_three_o),
    .gp_pin_three_oe_n_o(gp_pin_three_oe_n_o), .gp_pin_two_o(gp_pin_two_o),
    .gp_pin_two_oe_n_o(gp_pin_two_oe_n_o), .eeprom_scl_o(eeprom_scl_o), .eeprom_sda_o(eeprom_sda_o),
    .link_gate_request_i(link_gate_request_i), .bus_gate_request_i(bus_gate_request_i),
    .link_clock_enable_o(link_clock_enable_o), .bus_clock_enable_o(bus_clock_enable_o),
    .multifunction_pin_six_i(multifunction_pin_six_i), .multifunction_pin_six_o(multifunction_pin_six_o),
    .multifunction_pin_six_oe_n_o(multifunction_pin_six_oe_n_o), .bus_clock_stop_ok_o(bus_clock_stop_ok_o));

  mc_link_core_model mc_link_core_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .link_req_i(link_req_i),
    .link_clock_running_i(link_clock_running_i), .delay_i(delay), .ack_o(link_core_ack_i),
    .rdata_o(link_core_rdata_i));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic check_value(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One access, answer expected on the next edge only if hit
  task automatic cfg(input logic wr, input logic [7:0] addr, input logic [3:0] be, input logic [31:0] data,
                     input logic hit);
    cfg_req_i = 1'b1;
    cfg_wr_i = wr;
    cfg_addr_i = addr;
    cfg_be_i = be;
    cfg_wdata_i = data;
    step(1);
    cfg_req_i = 1'b0;
    check_value(32'(cfg_ack_o), 32'(hit));
    step(1);
  endtask

  // Write the low half, then let derived outputs catch up
  task automatic set_cfg(input logic [15:0] v);
    cfg(1'b1, MC_CFG_OFFSET, 4'h3, {16'hffff, v}, 1'b1);
    step(1);
  endtask

  task automatic read_check(input logic [31:0] exp);
    cfg(1'b0, MC_CFG_OFFSET, 4'hf, 32'h0, 1'b1);
    check_value(cfg_rdata_o, exp);
  endtask

  function automatic logic [3:0] exp_cmd(input logic [1:0] sel, input logic [7:0] ph);
    if (ph <= 8'h02) return MC_CMD_MEM_READ;
    return (sel == MC_SEL_READ) ? MC_CMD_MEM_READ : (sel == MC_SEL_MULT) ? MC_CMD_READ_MULT : MC_CMD_READ_LINE;
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_access();
    read_check(32'h0);
    cfg(1'b1, MC_CFG_OFFSET, 4'hf, 32'hffffffff, 1'b1);
    read_check(32'h0000871f);
    cfg(1'b1, MC_CFG_OFFSET, 4'h1, 32'h0, 1'b1);
    read_check(32'h00008700);
    cfg(1'b1, MC_CFG_OFFSET, 4'hc, 32'h0, 1'b1);
    cfg(1'b1, 8'hf4, 4'hf, 32'h0, 1'b0);
    read_check(32'h00008700);
    cfg(1'b1, MC_CFG_OFFSET, 4'h2, 32'h0, 1'b1);
    read_check(32'h0);
  endtask

  // Walks bit 10, master gate and an unmasked event in all combinations
  task automatic t_pme();
    for (int i = 0; i < 8; i++) begin
      set_cfg(i[2] ? 16'h8400 : 16'h0000);
      master_interrupt_gate_i = i[1];
      irq_event_i = 32'h00000100;
      irq_mask_i = i[0] ? 32'h00000100 : 32'h00000200;
      step(1);
      check_value(32'(pme_request_o), 32'(i[0] & (i[1] | i[2])));
      check_value(32'(vendor_pme_ignore_o), 32'(i[2]));
      check_value(32'(pme_from_cold_support_o), 32'(i[2]));
    end
  endtask

  // Back-to-back master reads across every field code, with short and long lengths
  task automatic t_mrd();
    logic [7:0] ph [4];
    ph = '{8'h01, 8'h02, 8'h03, 8'hff};
    for (int s = 0; s < 4; s++) begin
      set_cfg({6'h0, 2'(s), 8'h00});
      mrd_req_i = 1'b1;
      for (int p = 0; p < 4; p++) begin
        mrd_phases_i = ph[p];
        step(1);
        check_value({27'h0, mrd_valid_o, mrd_cmd_o}, {28'h1, exp_cmd(2'(s), ph[p])});
      end
      mrd_req_i = 1'b0;
      step(1);
      check_value(32'(mrd_valid_o), 32'h0);
    end
    eeprom_word12_i = 2'h2;
    eeprom_load_i = 1'b1;
    step(1);
    eeprom_load_i = 1'b0;
    read_check(32'h00000200);
  endtask

  task automatic wait_valid();
    int n;
    n = 0;
    while (link_resp_valid_o !== 1'b1) begin
      if (n == 8) begin
        failures++;
        tally_and_finish();
      end
      step(1);
      n++;
    end
  endtask

  // Stopped clock answers by mode, running clock answers from the core
  task automatic t_link();
    for (int b = 0; b < 2; b++) begin
      set_cfg(b[0] ? 16'h0010 : 16'h0000);
      link_clock_running_i = 1'b0;
      link_req_i = 1'b1;
      step(1);
      link_req_i = 1'b0;
      check_value({31'h0, link_resp_valid_o}, 32'h1);
      check_value(32'(link_resp_abort_o), 32'(!b[0]));
      check_value(link_resp_data_o, b[0] ? MC_FILL_WORD : 32'h0);
    end
    for (int d = 0; d < 3; d += 2) begin
      delay = 2'(d);
      link_clock_running_i = 1'b1;
      link_req_i = 1'b1;
      step(1);
      link_req_i = 1'b0;
      check_value(32'(link_resp_valid_o), 32'h0);
      wait_valid();
      check_value({link_resp_abort_o, link_resp_data_o[30:0]}, 32'h1234abcd);
    end
  endtask

  // Pin routing with bit 3 set, then normal drive with it clear
  task automatic t_pins();
    gpio_three_drive_i = 1'b1;
    gpio_two_drive_i = 1'b1;
    set_cfg(16'h0008);
    for (int i = 0; i < 4; i++) begin
      ext_three = i[0];
      ext_two = i[1];
      step(1);
      check_value(32'({gp_pin_three_oe_n_o, gp_pin_two_oe_n_o, eeprom_scl_o, eeprom_sda_o}),
                  32'({2'h3, i[0], i[1]}));
    end
    gpio_three_out_i = 1'b1;
    gpio_two_out_i = 1'b1;
    gpio_two_drive_i = 1'b0;
    set_cfg(16'h0000);
    check_value(32'({gp_pin_three_oe_n_o, gp_pin_three_o, gp_pin_two_oe_n_o, gp_pin_two_o, eeprom_scl_o,
                     eeprom_sda_o}), 32'h1f);
  endtask

  task automatic t_clocks();
    for (int i = 0; i < 8; i++) begin
      link_gate_request_i = i[0];
      bus_gate_request_i = i[0];
      set_cfg({13'h0, i[2], i[1], 1'b0});
      check_value(32'({link_clock_enable_o, bus_clock_enable_o}),
                  32'({i[2] | i[0], i[1] | i[0]}));
    end
  endtask

  // Clock-run keep request, then fields kept across bus reset and cleared by global reset
  task automatic t_clkrun_sticky();
    logic seen_low;
    set_cfg(16'h0000);
    check_value(32'({bus_clock_stop_ok_o, multifunction_pin_six_oe_n_o, multifunction_pin_six_o}), 32'h6);
    set_cfg(16'h0001);
    seen_low = 1'b0;
    repeat (2) begin
      if (multifunction_pin_six_oe_n_o === 1'b0) seen_low = 1'b1;
      check_value(32'(bus_clock_stop_ok_o), 32'h0);
      step(1);
    end
    check_value(32'(seen_low), 32'h1);
    set_cfg(16'h871f);
    bus_reset_i = 1'b1;
    cfg(1'b0, MC_CFG_OFFSET, 4'hf, 32'h0, 1'b0);
    bus_reset_i = 1'b0;
    read_check(32'h0000871f);
    reset_n_i = 1'b0;
    step(2);
    reset_n_i = 1'b1;
    read_check(32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    step(6);
    check_value(32'({eeprom_scl_o, eeprom_sda_o, gp_pin_three_oe_n_o, gp_pin_two_oe_n_o,
                     multifunction_pin_six_oe_n_o}), 32'h1f);
    reset_n_i = 1'b1;
    t_access();
    t_pme();
    t_mrd();
    t_link();
    t_pins();
    t_clocks();
    t_clkrun_sticky();
    tally_and_finish();
  end
endmodule // tb_pci_misc_config_register

// ---- logic/mc_link_guard.sv ----
// Answers bus accesses to link registers, covering a stopped link clock
`timescale 1ns/10ps
module mc_link_guard import mc_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Mode from the configuration register
  input wire logic suppress_target_abort_i,
  // Access from the bus side
  input wire logic link_req_i,
  input wire logic link_clock_running_i,
  // Answer from the link core
  input wire logic link_core_ack_i,
  input wire logic [31:0] link_core_rdata_i,
  // Answer to the bus side
  output logic resp_valid_o,
  output logic resp_abort_o,
  output logic [31:0] resp_data_o
);

  mc_guard_s st;
  mc_guard_s next_st;

  // Stopped clock answers locally; running clock passes the core's answer
  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    next_st.abort = 1'b0;
    if (link_req_i && !link_clock_running_i) begin
      next_st.valid = 1'b1;
      next_st.abort = !suppress_target_abort_i;
      next_st.data = suppress_target_abort_i ? MC_FILL_WORD : '0;
    end else if (link_core_ack_i) begin
      next_st.valid = 1'b1;
      next_st.data = link_core_rdata_i;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign resp_valid_o = st.valid;
  assign resp_abort_o = st.abort;
  assign resp_data_o = st.data;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_stopped_abort;
    link_req_i && !link_clock_running_i && !suppress_target_abort_i |=> resp_valid_o && resp_abort_o;
  endproperty
  a_stopped_abort: assert property (p_stopped_abort) else $error("stopped link access not aborted");

  property p_stopped_fill;
    link_req_i && !link_clock_running_i && suppress_target_abort_i
      |=> resp_valid_o && !resp_abort_o && resp_data_o == MC_FILL_WORD;
  endproperty
  a_stopped_fill: assert property (p_stopped_fill) else $error("stopped link access not filled");

  c_fill: cover property (link_req_i && !link_clock_running_i && suppress_target_abort_i);

endmodule // mc_link_guard

// ---- logic/mc_misc_config.sv ----
// Miscellaneous bus configuration register and the logic it steers
`timescale 1ns/10ps
module mc_misc_config import mc_pkg::*; (
  // Clock and resets; reset_n_i is the global reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic bus_reset_i,

  // Configuration space access
  input wire logic cfg_req_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,

  // Serial EEPROM loader
  input wire logic eeprom_load_i,
  input wire logic [1:0] eeprom_word12_i,

  // Mirrors into other registers
  output logic pme_from_cold_support_o,
  output logic vendor_pme_ignore_o,

  // Power management event
  input wire logic [31:0] irq_event_i,
  input wire logic [31:0] irq_mask_i,
  input wire logic master_interrupt_gate_i,
  output logic pme_request_o,

  // Bus master reads
  input wire logic mrd_req_i,
  input wire logic [7:0] mrd_phases_i,
  output logic mrd_valid_o,
  output logic [3:0] mrd_cmd_o,

  // Link register access
  input wire logic link_req_i,
  input wire logic link_clock_running_i,
  input wire logic link_core_ack_i,
  input wire logic [31:0] link_core_rdata_i,
  output logic link_resp_valid_o,
  output logic link_resp_abort_o,
  output logic [31:0] link_resp_data_o,
  // General-purpose pins and serial EEPROM bus
  input wire logic gp_pin_three_i,
  input wire logic gp_pin_two_i,
  input wire logic gpio_three_out_i,
  input wire logic gpio_three_drive_i,
  input wire logic gpio_two_out_i,
  input wire logic gpio_two_drive_i,
  output logic gp_pin_three_o,
  output logic gp_pin_three_oe_n_o,
  output logic gp_pin_two_o,
  output logic gp_pin_two_oe_n_o,
  output logic eeprom_scl_o,
  output logic eeprom_sda_o,
  // Clock gating
  input wire logic link_gate_request_i,
  input wire logic bus_gate_request_i,
  output logic link_clock_enable_o,
  output logic bus_clock_enable_o,
  // Clock-run on multifunction pin six
  input wire logic multifunction_pin_six_i,
  output logic multifunction_pin_six_o,
  output logic multifunction_pin_six_oe_n_o,
  output logic bus_clock_stop_ok_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mc_state_s st;
  mc_state_s next_st;

  logic hit;
  logic [15:0] byte_mask;
  logic [15:0] wr_mask;
  logic irq_pending;
  logic [1:0] sel;

  // Decode of the access and byte lanes
  assign hit = cfg_req_i && (cfg_addr_i == MC_CFG_OFFSET);
  assign byte_mask = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
  assign wr_mask = byte_mask & MC_CFG_WMASK;
  assign irq_pending = |(irq_event_i & irq_mask_i);
  assign sel = st.cfg[MC_BIT_MRD_HI:MC_BIT_MRD_LO];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Register access; bus reset leaves the fields alone since they are sticky
    next_st.ack = hit;
    if (hit) begin
      next_st.rdata = {MC_UPPER_ZERO, st.cfg & MC_CFG_WMASK};
      if (cfg_wr_i) begin
        next_st.cfg = (st.cfg & ~wr_mask)
          | (cfg_wdata_i[15:0] & wr_mask);
      end
    end
    if (bus_reset_i) begin
      next_st.ack = 1'b0;
    end
    // EEPROM load lands after any write in the same cycle
    if (eeprom_load_i) begin
      next_st.cfg[MC_BIT_MRD_HI:MC_BIT_MRD_LO] = eeprom_word12_i;
    end

    // Mirrors into capability and vendor registers
    next_st.pme_cold = st.cfg[MC_BIT_PME_COLD];
    next_st.vendor_pme = st.cfg[MC_BIT_PME_IGNORE];

    // Master gate only matters while the decouple bit is clear
    next_st.pme = irq_pending
      && (master_interrupt_gate_i || st.cfg[MC_BIT_PME_IGNORE]);

    // Read command choice
    next_st.mrd_valid = mrd_req_i;
    if (mrd_req_i) begin
      if (mrd_phases_i <= MC_SHORT_PHASES) begin
        next_st.mrd_cmd = MC_CMD_MEM_READ;
      end else if (sel == MC_SEL_READ) begin
        next_st.mrd_cmd = MC_CMD_MEM_READ;
      end else if (sel == MC_SEL_MULT) begin
        next_st.mrd_cmd = MC_CMD_READ_MULT;
      end else begin
        next_st.mrd_cmd = MC_CMD_READ_LINE;
      end
    end

    // Pins float and feed the EEPROM bus when routed; idle bus reads high
    if (st.cfg[MC_BIT_GP_EEPROM]) begin
      next_st.gp3_oe_n = 1'b1;
      next_st.gp2_oe_n = 1'b1;
      next_st.gp3_out = 1'b0;
      next_st.gp2_out = 1'b0;
      next_st.scl = gp_pin_three_i;
      next_st.sda = gp_pin_two_i;
    end else begin
      next_st.gp3_oe_n = !gpio_three_drive_i;
      next_st.gp2_oe_n = !gpio_two_drive_i;
      next_st.gp3_out = gpio_three_out_i;
      next_st.gp2_out = gpio_two_out_i;
      next_st.scl = 1'b1;
      next_st.sda = 1'b1;
    end

    // Clock gate enables; bypass is a test feature only
    next_st.link_clk_en = st.cfg[MC_BIT_LINK_BYPASS] || link_gate_request_i;
    next_st.bus_clk_en = st.cfg[MC_BIT_BUS_BYPASS] || bus_gate_request_i;

    // Clock-run: pull the pin low to keep the clock when asked to stop
    next_st.mf6_out = 1'b0;
    next_st.mf6_oe_n = !(st.cfg[MC_BIT_KEEP_CLK] && multifunction_pin_six_i);
    next_st.clk_stop_ok = !st.cfg[MC_BIT_KEEP_CLK] && multifunction_pin_six_i;
  end

  // ----------------------------------------------------------------
  // Registers, cleared only by the global reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
      // Pins released and serial bus idle high out of reset
      st.cfg <= MC_CFG_RESET;
      st.scl <= 1'b1;
      st.sda <= 1'b1;
      st.gp3_oe_n <= 1'b1;
      st.gp2_oe_n <= 1'b1;
      st.mf6_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Link access guard
  // ----------------------------------------------------------------
  mc_link_guard mc_link_guard_inst (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .suppress_target_abort_i(st.cfg[MC_BIT_NO_ABORT]),
    .link_req_i(link_req_i),
    .link_clock_running_i(link_clock_running_i),
    .link_core_ack_i(link_core_ack_i),
    .link_core_rdata_i(link_core_rdata_i),
    .resp_valid_o(link_resp_valid_o),
    .resp_abort_o(link_resp_abort_o),
    .resp_data_o(link_resp_data_o)
  );

  // Outputs straight from state flops
  assign cfg_ack_o = st.ack;
  assign cfg_rdata_o = st.rdata;
  assign pme_from_cold_support_o = st.pme_cold;
  assign vendor_pme_ignore_o = st.vendor_pme;
  assign pme_request_o = st.pme;
  assign mrd_valid_o = st.mrd_valid;
  assign mrd_cmd_o = st.mrd_cmd;
  assign gp_pin_three_o = st.gp3_out;
  assign gp_pin_three_oe_n_o = st.gp3_oe_n;
  assign gp_pin_two_o = st.gp2_out;
  assign gp_pin_two_oe_n_o = st.gp2_oe_n;
  assign eeprom_scl_o = st.scl;
  assign eeprom_sda_o = st.sda;
  assign link_clock_enable_o = st.link_clk_en;
  assign bus_clock_enable_o = st.bus_clk_en;
  assign multifunction_pin_six_o = st.mf6_out;
  assign multifunction_pin_six_oe_n_o = st.mf6_oe_n;
  assign bus_clock_stop_ok_o = st.clk_stop_ok;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_upper_zero;
    cfg_ack_o |-> cfg_rdata_o[31:16] == MC_UPPER_ZERO;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper half not zero");

  property p_reserved_zero;
    cfg_ack_o |-> cfg_rdata_o[14:11] == 4'h0 && cfg_rdata_o[7:5] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_write_read;
    hit && cfg_wr_i && cfg_be_i[1]
      |=> st.cfg[MC_BIT_PME_COLD] == $past(cfg_wdata_i[MC_BIT_PME_COLD]);
  endproperty
  a_write_read: assert property (p_write_read) else $error("written bit not stored");

  property p_cold_mirror;
    ##1 pme_from_cold_support_o == $past(st.cfg[MC_BIT_PME_COLD]);
  endproperty
  a_cold_mirror: assert property (p_cold_mirror) else $error("cold PME mirror wrong");

  property p_vendor_mirror;
    st.cfg[MC_BIT_PME_IGNORE] ##1 st.cfg[MC_BIT_PME_IGNORE] |=> vendor_pme_ignore_o;
  endproperty
  a_vendor_mirror: assert property (p_vendor_mirror) else $error("vendor bit not set");

  property p_pme_gate;
    irq_pending && !master_interrupt_gate_i
      |=> pme_request_o == $past(st.cfg[MC_BIT_PME_IGNORE]);
  endproperty
  a_pme_gate: assert property (p_pme_gate) else $error("PME gating wrong");

  property p_short_read;
    mrd_req_i && mrd_phases_i <= MC_SHORT_PHASES
      |=> mrd_valid_o && mrd_cmd_o == MC_CMD_MEM_READ;
  endproperty
  a_short_read: assert property (p_short_read) else $error("short read command wrong");

  property p_long_reserved;
    mrd_req_i && mrd_phases_i > MC_SHORT_PHASES && sel == 2'h3
      |=> mrd_cmd_o == MC_CMD_READ_LINE;
  endproperty
  a_long_reserved: assert property (p_long_reserved) else $error("reserved select not line read");

  property p_eeprom_load;
    eeprom_load_i |=> sel == $past(eeprom_word12_i);
  endproperty
  a_eeprom_load: assert property (p_eeprom_load) else $error("EEPROM load lost");

  property p_pins_float;
    st.cfg[MC_BIT_GP_EEPROM]
      |=> gp_pin_three_oe_n_o && gp_pin_two_oe_n_o && eeprom_scl_o == $past(gp_pin_three_i);
  endproperty
  a_pins_float: assert property (p_pins_float) else $error("pins not routed to EEPROM bus");

  property p_bypass;
    st.cfg[MC_BIT_LINK_BYPASS] && st.cfg[MC_BIT_BUS_BYPASS]
      |=> link_clock_enable_o && bus_clock_enable_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("clock gate bypass ignored");

  property p_keep_clock;
    st.cfg[MC_BIT_KEEP_CLK] && multifunction_pin_six_i
      |=> !multifunction_pin_six_oe_n_o && !bus_clock_stop_ok_o;
  endproperty
  a_keep_clock: assert property (p_keep_clock) else $error("clock-run keep not driven");

  property p_sticky;
    bus_reset_i && !hit && !eeprom_load_i |=> $stable(st.cfg);
  endproperty
  a_sticky: assert property (p_sticky) else $error("bus reset changed fields");

  c_write: cover property (hit && cfg_wr_i);
  c_long_mult: cover property (mrd_req_i && mrd_phases_i > MC_SHORT_PHASES
    && sel == MC_SEL_MULT);
  c_pme_decoupled: cover property (irq_pending && !master_interrupt_gate_i
    && st.cfg[MC_BIT_PME_IGNORE]);
  c_stop_ok: cover property (bus_clock_stop_ok_o);

endmodule // mc_misc_config

// ---- shared/mc_pkg.sv ----
// Constants and state types for the miscellaneous bus configuration register
// What this block does
// - Bits 31..16 read zero, writes ignored
// - Bit 15 drives cold-state PME support flag
// - Bits 14..11 read zero, writes ignored
// - Bit 10 decouples PME from master gate
// - Bit 10 mirrored into vendor register bit
// - Field 9..8 picks long read command
// - Short reads always use plain memory read
// - EEPROM word loads read command field
// - Bits 7..5 read zero, writes ignored
// - Bit 4 swaps target abort for data
// - Stopped link clock: abort or FFh data
// - Bit 3 routes pins to EEPROM bus
// - Bit 2 bypasses link clock gating
// - Bit 1 bypasses bus clock gating
// - Bit 0 keeps bus clock via clock-run
// - Fields cleared only by global reset
package mc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MC_CFG_OFFSET = 8'hf0;
  localparam logic [7:0] MC_PM_CAP_OFFSET = 8'h46;
  localparam logic [7:0] MC_VENDOR_OFFSET = 8'h40;
  localparam logic [15:0] MC_CFG_RESET = 16'h0000;
  localparam logic [15:0] MC_CFG_WMASK = 16'h871f;
  localparam logic [15:0] MC_UPPER_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MC_BIT_PME_COLD = 15;
  localparam int MC_BIT_PME_IGNORE = 10;
  localparam int MC_BIT_MRD_HI = 9;
  localparam int MC_BIT_MRD_LO = 8;
  localparam int MC_BIT_NO_ABORT = 4;
  localparam int MC_BIT_GP_EEPROM = 3;
  localparam int MC_BIT_LINK_BYPASS = 2;
  localparam int MC_BIT_BUS_BYPASS = 1;
  localparam int MC_BIT_KEEP_CLK = 0;
  localparam int MC_VENDOR_PME_BIT = 26;
  localparam int MC_PM_CAP_COLD_BIT = 15;

  // ----------------------------------------------------------------
  // Master read commands and field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MC_SEL_LINE = 2'h0;
  localparam logic [1:0] MC_SEL_READ = 2'h1;
  localparam logic [1:0] MC_SEL_MULT = 2'h2;
  localparam logic [3:0] MC_CMD_MEM_READ = 4'h6;
  localparam logic [3:0] MC_CMD_READ_LINE = 4'he;
  localparam logic [3:0] MC_CMD_READ_MULT = 4'hc;
  localparam logic [7:0] MC_SHORT_PHASES = 8'h02;

  // ----------------------------------------------------------------
  // Link access answers
  // ----------------------------------------------------------------
  localparam logic [7:0] MC_FILL_BYTE = 8'hff;
  localparam logic [31:0] MC_FILL_WORD = {4{MC_FILL_BYTE}};

  // ----------------------------------------------------------------
  // State of the register block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cfg;
    logic ack;
    logic [31:0] rdata;
    logic pme;
    logic mrd_valid;
    logic [3:0] mrd_cmd;
    logic scl;
    logic sda;
    logic gp3_out;
    logic gp3_oe_n;
    logic gp2_out;
    logic gp2_oe_n;
    logic link_clk_en;
    logic bus_clk_en;
    logic mf6_out;
    logic mf6_oe_n;
    logic clk_stop_ok;
    logic pme_cold;
    logic vendor_pme;
  } mc_state_s;

  // State of the link access guard
  typedef struct packed {
    logic valid;
    logic abort;
    logic [31:0] data;
  } mc_guard_s;

endpackage
